// ==== rtl/usc_pkg.sv ====
// Package for the USB status, control and address slice
// Operation
// R01: Status bits 7:4 report last endpoint number
// R02: Status bit 3 set for transmit
// R03: Status bit 2 set for odd bank
// R04: Four-entry status queue, oldest shown
// R05: Status valid only while done flag set
// R06: Clearing done flag pops the queue
// R07: Unimplemented bits read as zero
// R08: Control bits 7:6 show live line state
// R09: Device mode: SETUP sets packet hold
// R10: Host mode: bit 5 shows token busy
// R11: Software checks busy before next token
// R12: Bit 4 drives bus reset in host
// R13: Bit 3 enables host, toggle resets host
// R14: Bit 2 drives resume signalling
// R15: Software holds resume 10 or 25 ms
// R16: Host resume end appends low-speed EOP
// R17: Bit 1 forces ping-pong pointers even
// R18: Device mode: bit 0 enables module
// R19: Host mode: bit 0 sends SOF each ms
// R20: Address bit 7 selects low speed
// R21: Address bits 6:0 hold device address
// R22: Push per completion, no overwrite when full
package usc_pkg;
	localparam logic [11:0] STATUS_OFFSET = 12'h000;
	localparam logic [11:0] CONTROL_OFFSET = 12'h004;
	localparam logic [11:0] ADDRESS_OFFSET = 12'h008;
	localparam logic [11:0] DONE_OFFSET = 12'h00c;
	localparam int ENDP_MSB = 7;
	localparam int ENDP_LSB = 4;
	localparam int DIR_BIT = 3;
	localparam int BANK_BIT = 2;
	localparam int LINE_J_BIT = 7;
	localparam int SE0_BIT = 6;
	localparam int HOLD_BIT = 5;
	localparam int RST_BIT = 4;
	localparam int HOST_BIT = 3;
	localparam int RESUME_BIT = 2;
	localparam int PPCLR_BIT = 1;
	localparam int EN_BIT = 0;
	localparam int LS_BIT = 7;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] ADDRESS_RESET = 8'h00;
	localparam int FIFO_DEPTH = 4;
	localparam int CLK_HZ = 100000000;
	localparam int SOF_PERIOD_US = 1000;
	localparam int SOF_CYCLES = CLK_HZ / 1000000 * SOF_PERIOD_US;
	localparam int EOP_TIME_NS = 1330;
	localparam int EOP_CYCLES = (EOP_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;

	typedef struct packed {
		logic [3:0] endpoint;
		logic transmit;
		logic bankOdd;
	} usc_status_t;

	typedef struct packed {
		logic live_j_line_state;
		logic se0;
	} usc_line_t;
endpackage : usc_pkg

// ==== rtl/usc_status_fifo.sv ====
// Small status queue with registered read data
`timescale 1ns/100ps
module usc_status_fifo #(
	parameter int DEPTH = 4,
	parameter int WIDTH = 6
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic push,
	input wire logic [WIDTH-1:0] pushData,
	input wire logic pop,
	output logic [WIDTH-1:0] headData,
	output logic notEmpty,
	output logic full
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	wire doPop = pop && (count_r != '0);
	wire doPush = push && (count_r != (AW+1)'(DEPTH));
	wire [AW-1:0] rdNext = doPop ? rdPtr_r + 1'b1 : rdPtr_r;
	wire [AW:0] countNxt = count_r + (AW+1)'(doPush) - (AW+1)'(doPop);

	always_ff @(posedge core_clk) begin
		if (doPush)
			mem[wrPtr_r] <= pushData; // R22
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
			notEmpty <= 1'b0;
			full <= 1'b0;
			headData <= '0;
		end else begin
			wrPtr_r <= doPush ? wrPtr_r + 1'b1 : wrPtr_r;
			rdPtr_r <= rdNext; // R06
			count_r <= countNxt;
			notEmpty <= countNxt != '0;
			full <= countNxt == (AW+1)'(DEPTH);
			// Head follows a write into an empty queue without a bubble
			headData <= (doPush && countNxt == (AW+1)'(1)) ? pushData : mem[rdNext]; // R04
		end
	end
endmodule : usc_status_fifo

// ==== rtl/usb_status_control_address.sv ====
// Status queue, control and address registers of the USB link slice
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
module usb_status_control_address #(
	parameter int SOF_PERIOD = usc_pkg::SOF_CYCLES
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic lineJ,
	input wire logic lineSe0,
	input wire logic transactionDone,
	input wire logic [5:0] transactionInfo,
	input wire logic setupReceived,
	input wire logic tokenStart,
	input wire logic tokenEnd,
	output logic transactionDoneFlag,
	output logic packetProcessingHold,
	output logic tokenInProgress,
	output logic busResetDrive,
	output logic hostCapabilityEnable,
	output logic hostLogicReset,
	output logic resumeDrive,
	output logic lowSpeedEopDrive,
	output logic pingpongPointerClear,
	output logic modulePowerEnable,
	output logic frameStartPulse,
	output logic lowSpeedSelect,
	output logic [6:0] deviceBusAddress
);
	logic [1:0] jSync_r;
	logic [1:0] se0Sync_r;
	usc_pkg::usc_line_t line_r;
	logic [7:0] control_r;
	logic [7:0] address_r;
	logic busy_r;
	logic hostPrev_r;
	logic [31:0] sofCnt_r;
	logic [15:0] eopCnt_r;
	logic [31:0] rdata_nxt;
	logic qNotEmpty;
	logic qFull;
	usc_pkg::usc_status_t qHead;

	// APB: zero wait states; reads are sampled in the setup phase, writes land at the access phase
	wire access = psel && penable;
	wire wrEn = access && pwrite;
	wire hitStatus = paddr == usc_pkg::STATUS_OFFSET;
	wire hitControl = paddr == usc_pkg::CONTROL_OFFSET;
	wire hitAddress = paddr == usc_pkg::ADDRESS_OFFSET;
	wire hitDone = paddr == usc_pkg::DONE_OFFSET;
	wire mapped = hitStatus || hitControl || hitAddress || hitDone;
	wire wrControl = wrEn && hitControl;
	wire wrAddress = wrEn && hitAddress;
	// Done flag is write-one-to-clear; its clear pops the queue
	wire clearDone = wrEn && hitDone && pwdata[0];
	wire popQueue = clearDone && qNotEmpty; // R06
	wire hostMode = control_r[usc_pkg::HOST_BIT];
	wire [7:0] controlWr = pwdata[7:0];
	wire holdSet = setupReceived && !hostMode; // R09
	wire resumeFall = control_r[usc_pkg::RESUME_BIT] && wrControl &&
		!controlWr[usc_pkg::RESUME_BIT];
	wire sofRun = hostMode && control_r[usc_pkg::EN_BIT]; // R19
	wire sofWrap = sofCnt_r == 32'(SOF_PERIOD - 1);

	// Software writes bit 5 in either mode; hardware setup wins over clear
	wire holdNxt = holdSet ? 1'b1 :
		(wrControl ? controlWr[usc_pkg::HOLD_BIT] : control_r[usc_pkg::HOLD_BIT]);
	wire [7:0] controlNxt = wrControl ?
		{2'b00, holdNxt, controlWr[4:0]} :
		{2'b00, holdNxt, control_r[4:0]};

	// Status valid only when the done flag shows an entry
	wire [7:0] statusByte = qNotEmpty ?
		{qHead.endpoint, qHead.transmit, qHead.bankOdd, 2'b00} : 8'h00; // R01 R02 R03 R05 R07
	wire [7:0] controlByte = {line_r.live_j_line_state, line_r.se0,
		hostMode ? busy_r : control_r[usc_pkg::HOLD_BIT], control_r[4:0]}; // R08 R10

	always_comb begin
		rdata_nxt = 32'h00000000; // R07
		if (hitStatus)
			rdata_nxt = {24'h000000, statusByte};
		else if (hitControl)
			rdata_nxt = {24'h000000, controlByte};
		else if (hitAddress)
			rdata_nxt = {24'h000000, address_r};
		else if (hitDone)
			rdata_nxt = {31'h00000000, qNotEmpty};
	end

	usc_status_fifo #(
		.DEPTH(usc_pkg::FIFO_DEPTH),
		.WIDTH(6)
	) u_fifo (
		.core_clk(core_clk),
		.reset(reset),
		.push(transactionDone), // R22
		.pushData(transactionInfo),
		.pop(popQueue),
		.headData(qHead),
		.notEmpty(qNotEmpty),
		.full(qFull)
	);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			jSync_r <= 2'b00;
			se0Sync_r <= 2'b00;
			line_r <= '0;
		end else begin
			jSync_r <= {jSync_r[0], lineJ};
			se0Sync_r <= {se0Sync_r[0], lineSe0};
			line_r <= '{live_j_line_state: jSync_r[1], se0: se0Sync_r[1]}; // R08
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			control_r <= usc_pkg::CONTROL_RESET;
			address_r <= usc_pkg::ADDRESS_RESET;
		end else begin
			control_r <= controlNxt;
			if (wrAddress)
				address_r <= pwdata[7:0]; // R20 R21
		end
	end

	// Token busy; a toggle of host enable clears host state
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			busy_r <= 1'b0;
			hostPrev_r <= 1'b0;
		end else begin
			hostPrev_r <= hostMode;
			if (hostPrev_r != hostMode || !hostMode)
				busy_r <= 1'b0; // R13
			else if (tokenStart)
				busy_r <= 1'b1; // R10
			else if (tokenEnd)
				busy_r <= 1'b0;
		end
	end

	// Frame timer counts only while running, restarts at every frame
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			sofCnt_r <= 32'h00000000;
			frameStartPulse <= 1'b0;
		end else begin
			frameStartPulse <= sofRun && sofWrap; // R19
			if (!sofRun || sofWrap || hostPrev_r != hostMode)
				sofCnt_r <= 32'h00000000;
			else
				sofCnt_r <= sofCnt_r + 32'h00000001;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			eopCnt_r <= 16'h0000;
		end else if (resumeFall && hostMode) begin
			eopCnt_r <= 16'(usc_pkg::EOP_CYCLES); // R16
		end else if (eopCnt_r != 16'h0000) begin
			eopCnt_r <= eopCnt_r - 16'h0001;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			transactionDoneFlag <= 1'b0;
			packetProcessingHold <= 1'b0;
			tokenInProgress <= 1'b0;
			busResetDrive <= 1'b0;
			hostCapabilityEnable <= 1'b0;
			hostLogicReset <= 1'b0;
			resumeDrive <= 1'b0;
			lowSpeedEopDrive <= 1'b0;
			pingpongPointerClear <= 1'b0;
			modulePowerEnable <= 1'b0;
			lowSpeedSelect <= 1'b0;
			deviceBusAddress <= 7'h00;
		end else begin
			prdata <= (psel && !penable && !pwrite) ? rdata_nxt : prdata;
			pready <= psel && !penable;
			pslverr <= psel && !penable && !mapped;
			transactionDoneFlag <= qNotEmpty;
			packetProcessingHold <= !hostMode && control_r[usc_pkg::HOLD_BIT]; // R09
			tokenInProgress <= busy_r;
			busResetDrive <= hostMode && control_r[usc_pkg::RST_BIT]; // R12
			hostCapabilityEnable <= hostMode; // R13
			hostLogicReset <= hostPrev_r != hostMode; // R13
			resumeDrive <= control_r[usc_pkg::RESUME_BIT]; // R14
			lowSpeedEopDrive <= eopCnt_r != 16'h0000; // R16
			pingpongPointerClear <= control_r[usc_pkg::PPCLR_BIT]; // R17
			modulePowerEnable <= !hostMode && control_r[usc_pkg::EN_BIT]; // R18
			lowSpeedSelect <= address_r[usc_pkg::LS_BIT]; // R20
			deviceBusAddress <= address_r[6:0]; // R21
		end
	end

	property p_full_holds;
		@(posedge core_clk) disable iff (reset)
		qFull && transactionDone && !popQueue |=> qFull && $stable(qHead);
	endproperty
	a_full_holds: assert property (p_full_holds) else $error("queue lost full"); // R22

	property p_pop;
		@(posedge core_clk) disable iff (reset)
		popQueue && !transactionDone |=> !qFull;
	endproperty
	a_pop: assert property (p_pop) else $error("pop failed"); // R06

	property p_hold;
		@(posedge core_clk) disable iff (reset)
		holdSet |=> control_r[usc_pkg::HOLD_BIT] ##1 packetProcessingHold || hostMode;
	endproperty
	a_hold: assert property (p_hold) else $error("setup did not set hold"); // R09

	property p_busy;
		@(posedge core_clk) disable iff (reset)
		hostMode && hostPrev_r && tokenStart |=> busy_r ##1 tokenInProgress;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not set"); // R10

	property p_reset_drive;
		@(posedge core_clk) disable iff (reset)
		busResetDrive |-> $past(hostMode) && $past(control_r[usc_pkg::RST_BIT]);
	endproperty
	a_reset_drive: assert property (p_reset_drive) else $error("bus reset wrong"); // R12

	property p_toggle;
		@(posedge core_clk) disable iff (reset)
		$changed(hostMode) |=> hostLogicReset && !busy_r;
	endproperty
	a_toggle: assert property (p_toggle) else $error("host reset missing"); // R13

	property p_eop;
		@(posedge core_clk) disable iff (reset)
		resumeFall && hostMode |=> ##1 lowSpeedEopDrive;
	endproperty
	a_eop: assert property (p_eop) else $error("no low-speed eop"); // R16

	property p_sof;
		@(posedge core_clk) disable iff (reset)
		frameStartPulse |-> $past(sofRun);
	endproperty
	a_sof: assert property (p_sof) else $error("sof while disabled"); // R19

	property p_status_zero;
		@(posedge core_clk) disable iff (reset)
		!qNotEmpty |-> statusByte == 8'h00 && rdata_nxt[31:8] == 24'h000000;
	endproperty
	a_status_zero: assert property (p_status_zero) else $error("invalid status shown"); // R05
endmodule : usb_status_control_address

// ==== dv/usc_bus_model.sv ====
// Far-side bus model: live line levels and transfer event pulses
`timescale 1ns/100ps
module usc_bus_model (
	input wire logic core_clk,
	output logic lineJ,
	output logic lineSe0,
	output logic transactionDone,
	output logic [5:0] transactionInfo,
	output logic setupReceived,
	output logic tokenStart,
	output logic tokenEnd
);
	initial begin
		{lineJ, lineSe0, transactionDone, transactionInfo} = '0;
		{setupReceived, tokenStart, tokenEnd} = '0;
	end
	// Line levels change at will; the design must synchronise them
	task automatic set_lines(input logic j, input logic se0);
		lineJ <= j;
		lineSe0 <= se0;
	endtask : set_lines
	// Each event lasts one clock; a trailing idle clock keeps pulses apart
	task automatic send(input int kind, input logic [5:0] info);
		transactionInfo <= info;
		transactionDone <= (kind == 0);
		setupReceived <= (kind == 1);
		tokenStart <= (kind == 2);
		tokenEnd <= (kind == 3);
		@(posedge core_clk);
		{transactionDone, setupReceived, tokenStart, tokenEnd} <= 4'h0;
		@(posedge core_clk);
	endtask : send
endmodule : usc_bus_model

// ==== dv/tb.sv ====
// Self-checking bench for the status, control and address slice
`timescale 1ns/100ps
module tb;
	localparam logic [11:0] ST = usc_pkg::STATUS_OFFSET;
	localparam logic [11:0] CT = usc_pkg::CONTROL_OFFSET;
	localparam logic [11:0] AD = usc_pkg::ADDRESS_OFFSET;
	localparam logic [11:0] DN = usc_pkg::DONE_OFFSET;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic lineJ, lineSe0, tDone, setupRx, tokStart, tokEnd, doneFlag, hold, busy;
	logic busRst, host_capability_enable, hostRst, resume, lsEop, ppClr, modEn, sofPulse, lowSpd;
	logic [5:0] tInfo;
	logic [6:0] device_bus_address;
	logic [5:0] infos [5] = '{6'h3f, 6'h05, 6'h2a, 6'h10, 6'h01};
	int miscompares = 0;
	int checked = 0;
	int sofCount = 0;
	int hostRstCount = 0;

	usb_status_control_address #(.SOF_PERIOD(20)) i_usb_status_control_address (
		.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .lineJ(lineJ), .lineSe0(lineSe0),
		.transactionDone(tDone), .transactionInfo(tInfo), .setupReceived(setupRx),
		.tokenStart(tokStart), .tokenEnd(tokEnd), .transactionDoneFlag(doneFlag),
		.packetProcessingHold(hold), .tokenInProgress(busy), .busResetDrive(busRst),
		.hostCapabilityEnable(host_capability_enable), .hostLogicReset(hostRst), .resumeDrive(resume),
		.lowSpeedEopDrive(lsEop), .pingpongPointerClear(ppClr),
		.modulePowerEnable(modEn), .frameStartPulse(sofPulse),
		.lowSpeedSelect(lowSpd), .deviceBusAddress(device_bus_address));
	usc_bus_model i_usc_bus_model (
		.core_clk(core_clk), .lineJ(lineJ), .lineSe0(lineSe0), .transactionDone(tDone),
		.transactionInfo(tInfo), .setupReceived(setupRx), .tokenStart(tokStart),
		.tokenEnd(tokEnd));

	always @(posedge core_clk) begin
		if (sofPulse === 1'b1) sofCount++;
		if (hostRst === 1'b1) hostRstCount++;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Entered just after an edge; leaves one idle clock so calls never collide
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) miscompares++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb

	task automatic end_sim();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		#200000;
		miscompares++;
		end_sim();
	end

	initial begin
		{reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 47'h0};
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		@(posedge core_clk);
		chk({busRst, host_capability_enable, modEn, lowSpd, device_bus_address, doneFlag}, 32'h0);
		apb(1'b0, CT, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, AD, 32'hffff_ffff);
		apb(1'b0, AD, 32'h0);
		chk(rd, 32'h0000_00ff);
		chk({lowSpd, device_bus_address}, 32'h0000_00ff);
		apb(1'b0, 12'h010, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (int i = 0; i < 5; i++) i_usc_bus_model.send(0, infos[i]);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, DN, 32'h0);
			chk(rd, 32'h1);
			chk({31'h0, doneFlag}, 32'h1);
			apb(1'b0, ST, 32'h0);
			chk(rd, {24'h0, infos[i], 2'b00});
			apb(1'b1, DN, 32'h1);
		end
		apb(1'b0, DN, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, ST, 32'h0);
		chk(rd, 32'h0);
		i_usc_bus_model.set_lines(1'b1, 1'b0);
		repeat (6) @(posedge core_clk);
		apb(1'b0, CT, 32'h0);
		chk(rd, 32'h0000_0080);
		i_usc_bus_model.set_lines(1'b0, 1'b1);
		repeat (6) @(posedge core_clk);
		apb(1'b1, CT, 32'h0000_0001);
		i_usc_bus_model.send(1, 6'h0);
		apb(1'b0, CT, 32'h0);
		chk(rd, 32'h0000_0061);
		chk({hold, modEn, busRst}, 32'h6);
		apb(1'b1, CT, 32'h0000_0000);
		apb(1'b1, CT, 32'h0000_0008);
		i_usc_bus_model.send(2, 6'h0);
		apb(1'b0, CT, 32'h0);
		chk(rd, 32'h0000_0068);
		chk({busy, host_capability_enable}, 32'h3);
		i_usc_bus_model.send(3, 6'h0);
		apb(1'b0, CT, 32'h0);
		chk(rd, 32'h0000_0048);
		apb(1'b1, CT, 32'h0000_001a);
		@(posedge core_clk);
		chk({busRst, ppClr, hold}, 32'h6);
		apb(1'b1, CT, 32'h0000_000c);
		// Resume hold shortened from 25 ms to keep the run brief
		repeat (25) @(posedge core_clk);
		chk({resume, busRst, ppClr}, 32'h4);
		apb(1'b1, CT, 32'h0000_0008);
		@(posedge core_clk);
		chk({resume, lsEop}, 32'h1);
		apb(1'b1, CT, 32'h0000_0009);
		sofCount = 0;
		repeat (210) @(posedge core_clk);
		chk(sofCount, 32'd10);
		apb(1'b1, CT, 32'h0000_0000);
		sofCount = 0;
		repeat (60) @(posedge core_clk);
		chk(sofCount, 32'd0);
		chk(hostRstCount, 32'd2);
		end_sim();
	end
endmodule : tb
